// [design/pwr_pkg.sv]
// Constants shared by the power-down controller and its data store.
// Assumes a single clock, clk_sys at 20 MHz, and an active-high asynchronous reset.
`default_nettype none
package pwr_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] power_control_register_addr = 12'h000;
	localparam logic [11:0] status_addr                 = 12'h004;
	localparam logic [11:0] general_ram_addr            = 12'h008;
	localparam logic [11:0] ram_window_base             = 12'h100;
	localparam logic [11:0] ram_window_mask             = 12'hf00;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int unsigned idle_arm_pos   = 0;
	localparam int unsigned arm_pos        = 1;
	localparam int unsigned flag0_pos      = 2;
	localparam int unsigned flag1_pos      = 3;
	localparam int unsigned idle_start_pos = 5;
	localparam int unsigned start_pos      = 6;
	localparam int unsigned smod_pos       = 7;
	localparam logic [7:0]  power_control_register_reset     = 8'h00;
	localparam logic [7:0]  scratch_reset  = 8'h00;
	localparam logic [7:0]  power_control_register_keep_mask = 8'h8c;
	localparam int unsigned ram_depth      = 64;
	localparam int unsigned ram_aw         = 6;
	// ----------------------------------------
	// Operating states
	// ----------------------------------------
	typedef enum logic [1:0] {st_run, st_idle, st_down} pmode_e;
endpackage : pwr_pkg
`default_nettype wire

// [design/pwr_ram.sv]
// Small internal data store, unaffected by reset.
// Assumes single-port use from the controller on clk_sys.
`default_nettype none
module pwr_ram (
	input  wire logic       clk_sys,     // System clock
	input  wire logic       we,          // Write strobe
	input  wire logic [5:0] addr,        // Word address
	input  wire logic [7:0] wdata,       // Write data
	output logic      [7:0] rdata        // Registered read data
);
	logic [7:0] mem [0:pwr_pkg::ram_depth-1];

	// Write and registered read; contents survive every reset
	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule : pwr_ram
`default_nettype wire

// [design/pwr_ctrl.sv]
// Power-down and idle entry controller with an APB register slave.
// Assumes APB master on clk_sys; the saving-enable pin and wake are asynchronous.
//
// The APB slave port and the address map were chosen for this implementation.
`default_nettype none
module pwr_ctrl (
	input  wire logic        clk_sys,           // System clock, 20 MHz
	input  wire logic        rst,               // Hardware reset, async, active high
	input  wire logic        psel,              // APB select
	input  wire logic        penable,           // APB access phase
	input  wire logic        pwrite,            // APB direction
	input  wire logic [11:0] paddr,             // APB byte address
	input  wire logic [31:0] pwdata,            // APB write data
	output logic      [31:0] prdata,            // APB read data
	output logic             pready,            // APB ready
	output logic             pslverr,           // APB error
	input  wire logic        power_saving_enable_pin_n, // Low enables saving modes
	input  wire logic        irq_wake,          // Interrupt request, ends idle only
	input  wire logic        ale_in,            // Address latch strobe from core
	input  wire logic        program_store_strobe_in, // Program strobe from core
	output logic             osc_enable,        // Oscillator runs while high
	output logic             core_clk_enable,   // Core clock gate
	output logic             ale_out,           // Address latch strobe to pin
	output logic             program_store_strobe_out, // Program strobe to pin
	output logic             powerdown_active,  // Device in power-down
	output logic             idle_active        // Device in idle
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] pe_sync_r, pe_sync_nxt;
	logic [1:0] wk_sync_r, wk_sync_nxt;

	// Two-stage sync of the asynchronous pins; first stage feeds only the second
	always_comb begin
		pe_sync_nxt = {pe_sync_r[0], power_saving_enable_pin_n};
		wk_sync_nxt = {wk_sync_r[0], irq_wake};
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pe_sync_r <= 2'h3;
			wk_sync_r <= 2'h0;
		end else begin
			pe_sync_r <= pe_sync_nxt;
			wk_sync_r <= wk_sync_nxt;
		end
	end

	logic saving_allowed;
	logic wake;
	assign saving_allowed = ~pe_sync_r[1];
	assign wake           = wk_sync_r[1];

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	pwr_pkg::pmode_e mode_r, mode_nxt;
	logic [7:0] power_control_register_r, power_control_register_nxt;
	logic [7:0] scratch_r, scratch_nxt;
	logic       armed_r, armed_nxt;
	logic       iarmed_r, iarmed_nxt;
	logic [7:0] ram_rdata;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
		hit = (a == b);
	endfunction : hit

	logic access, wr, rd, is_power_control_register, is_stat, is_gen, is_ram, mapped;
	logic [7:0] wb;
	assign access  = psel && penable && (mode_r != pwr_pkg::st_down);
	assign wr      = access && pwrite;
	// Reads are fetched at the setup edge so data stands through the access cycle
	assign rd      = psel && !penable && !pwrite && (mode_r != pwr_pkg::st_down);
	assign is_power_control_register = hit(paddr, pwr_pkg::power_control_register_addr);
	assign is_stat = hit(paddr, pwr_pkg::status_addr);
	assign is_gen  = hit(paddr, pwr_pkg::general_ram_addr);
	assign is_ram  = (paddr & pwr_pkg::ram_window_mask) == pwr_pkg::ram_window_base;
	assign mapped  = is_power_control_register || is_stat || is_gen || is_ram;
	assign wb      = pwdata[7:0];

	// Ready in one access cycle while awake; in power-down the bus never answers
	assign pready  = access;
	assign pslverr = access && !mapped;

	// ----------------------------------------
	// Sequence and mode control
	// ----------------------------------------
	logic pd_start, idle_start, power_control_register_wr;
	assign power_control_register_wr = wr && is_power_control_register; // Whole-word write only

	// Start counts only after an arm-only write and never with arm set too
	always_comb begin
		pd_start   = power_control_register_wr && wb[pwr_pkg::start_pos] && !wb[pwr_pkg::arm_pos]
			&& armed_r && saving_allowed;
		idle_start = power_control_register_wr && wb[pwr_pkg::idle_start_pos] && !wb[pwr_pkg::idle_arm_pos]
			&& iarmed_r && saving_allowed;
	end

	// Arm flags follow each control register write; any other control register write cancels them
	always_comb begin
		armed_nxt  = armed_r;
		iarmed_nxt = iarmed_r;
		if (power_control_register_wr) begin
			armed_nxt  = wb[pwr_pkg::arm_pos] && !wb[pwr_pkg::start_pos];
			iarmed_nxt = wb[pwr_pkg::idle_arm_pos] && !wb[pwr_pkg::idle_start_pos];
		end
	end

	// Only flag and baud bits are stored; self-clearing bits read zero
	always_comb begin
		power_control_register_nxt    = power_control_register_r;
		scratch_nxt = scratch_r;
		if (power_control_register_wr) begin
			power_control_register_nxt = wb & pwr_pkg::power_control_register_keep_mask;
		end
		if (wr && is_gen) begin
			scratch_nxt = wb;
		end
	end

	// Power-down is left only by reset; idle also ends on a wake request
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			pwr_pkg::st_run: begin
				if (pd_start) begin
					mode_nxt = pwr_pkg::st_down;
				end else if (idle_start) begin
					mode_nxt = pwr_pkg::st_idle;
				end
			end
			pwr_pkg::st_idle: begin
				if (wake) begin
					mode_nxt = pwr_pkg::st_run;
				end
			end
			pwr_pkg::st_down: begin
				mode_nxt = pwr_pkg::st_down; // Wake ignored
			end
		endcase
	end

	// Reset returns mode, control, scratch and arm flags to their reset values
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_r    <= pwr_pkg::st_run;
			power_control_register_r    <= pwr_pkg::power_control_register_reset;
			scratch_r <= pwr_pkg::scratch_reset;
			armed_r   <= 1'b0;
			iarmed_r  <= 1'b0;
		end else begin
			mode_r    <= mode_nxt;
			power_control_register_r    <= power_control_register_nxt;
			scratch_r <= scratch_nxt;
			armed_r   <= armed_nxt;
			iarmed_r  <= iarmed_nxt;
		end
	end

	// ----------------------------------------
	// Data store and read path
	// ----------------------------------------
	// Store has no reset so its contents survive power-down exit
	pwr_ram u_ram (
		.clk_sys (clk_sys),
		.we      (wr && is_ram),
		.addr    (paddr[pwr_pkg::ram_aw+1:2]),
		.wdata   (wb),
		.rdata   (ram_rdata)
	);

	logic ram_rd_r, ram_rd_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	// Every read is fetched in the setup phase, so data is ready in the access phase
	always_comb begin
		ram_rd_nxt = psel && !penable && is_ram;
		rdata_nxt  = rdata_r;
		if (rd) begin
			rdata_nxt = 32'h0000_0000;
			if (is_power_control_register) begin
				rdata_nxt = {24'h00_0000, power_control_register_r}; // Arm and start read zero
			end else if (is_stat) begin
				rdata_nxt = {28'h000_0000, saving_allowed, armed_r,
					mode_r == pwr_pkg::st_idle, mode_r == pwr_pkg::st_down};
			end else if (is_gen) begin
				rdata_nxt = {24'h00_0000, scratch_r};
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ram_rd_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
		end else begin
			ram_rd_r <= ram_rd_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	assign prdata = ram_rd_r ? {24'h00_0000, ram_rdata} : rdata_r;

	// ----------------------------------------
	// Clock gating and pin strobes
	// ----------------------------------------
	// Reset re-enables the oscillator at once
	assign osc_enable       = (mode_r != pwr_pkg::st_down);
	assign core_clk_enable  = (mode_r == pwr_pkg::st_run);
	assign powerdown_active = (mode_r == pwr_pkg::st_down);
	assign idle_active      = (mode_r == pwr_pkg::st_idle);
	// Strobes low in power-down, high in idle
	assign ale_out = powerdown_active ? 1'b0 : (idle_active | ale_in);
	assign program_store_strobe_out = powerdown_active ? 1'b0
		: (idle_active | program_store_strobe_in);
endmodule : pwr_ctrl
`default_nettype wire

// [verification/pwr_ctrl_monitor.sv]
// Checker for the power-down controller, watching the top ports only.
// Assumes one clock domain, clk_sys, with rst as asynchronous active-high reset.
`default_nettype none
module pwr_ctrl_monitor (
	input wire logic        clk_sys,                  // System clock
	input wire logic        rst,                      // Hardware reset
	input wire logic        psel,                     // APB select
	input wire logic        penable,                  // APB access phase
	input wire logic        pwrite,                   // APB direction
	input wire logic [11:0] paddr,                    // APB address
	input wire logic [31:0] pwdata,                   // APB write data
	input wire logic [31:0] prdata,                   // APB read data
	input wire logic        pready,                   // APB ready
	input wire logic        power_saving_enable_pin_n, // Saving enable
	input wire logic        osc_enable,               // Oscillator runs
	input wire logic        ale_out,                  // Latch strobe pin
	input wire logic        program_store_strobe_out, // Program strobe pin
	input wire logic        powerdown_active,         // In power-down
	input wire logic        idle_active               // In idle
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Helper: last two accepted control writes
	// ----------------------------------------
	logic [7:0] last_r;
	logic [7:0] prev_r;
	wire        ctl_acc = psel && penable && pready && paddr == 12'h000;
	// Shift register of control write data
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			last_r <= 8'h00;
			prev_r <= 8'h00;
		end else if (ctl_acc && pwrite) begin
			last_r <= pwdata[7:0];
			prev_r <= last_r;
		end
	end
	sequence ctl_read_s; ctl_acc && !pwrite; endsequence
	sequence start_seen_s; last_r[6] && !last_r[1]; endsequence
	sequence armed_before_s; prev_r[1] && !prev_r[6]; endsequence
	sequence pin_low_s; !power_saving_enable_pin_n [*4]; endsequence
	// Start-alone write right after an arm-alone write, while running
	sequence start_write_s;
		ctl_acc && pwrite && pwdata[6] && !pwdata[1] && last_r[1] && !last_r[6] && !idle_active;
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	pd_ready_off_a: assert property (powerdown_active |-> !pready)
		else $error("bus answered in power-down");
	pd_sticky_a: assert property (powerdown_active |=> powerdown_active)
		else $error("power-down left without reset");
	pd_osc_off_a: assert property (powerdown_active |-> !osc_enable)
		else $error("oscillator running in power-down");
	run_osc_on_a: assert property (!powerdown_active |-> osc_enable)
		else $error("oscillator stopped outside power-down");
	pd_strobes_low_a: assert property (
		powerdown_active |-> !ale_out && !program_store_strobe_out)
		else $error("strobes not low in power-down");
	pd_entry_order_a: assert property (
		$rose(powerdown_active) |-> start_seen_s ##0 armed_before_s)
		else $error("power-down without arm then start");
	pd_entry_now_a: assert property (pin_low_s ##0 start_write_s |=> powerdown_active)
		else $error("start write did not enter power-down");
	pin_blocks_entry_a: assert property (
		power_saving_enable_pin_n [*4] |=> !$rose(powerdown_active) && !$rose(idle_active))
		else $error("saving mode entered with pin high");
	ctl_read_zero_a: assert property (
		ctl_read_s |-> prdata[1] == 1'b0 && prdata[6] == 1'b0)
		else $error("arm or start bit read as one");
endmodule : pwr_ctrl_monitor
`default_nettype wire

// [verification/tb_power_down_entry_exit.sv]
// Self-checking bench for the power-down controller over APB.
// Assumes the package, design and monitor files are compiled before it.
`default_nettype none
module tb_power_down_entry_exit;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, rst, psel, penable, pwrite, pin_n, irq_wake, ale_in, ps_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, osc_enable, core_clk_enable, ale_out, ps_out, pd, idle;
	logic [7:0]  q;
	logic        e;
	int          n_errors, tests_run;
	// Clock at 20 MHz
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	pwr_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_saving_enable_pin_n(pin_n), .irq_wake(irq_wake),
		.ale_in(ale_in), .program_store_strobe_in(ps_in), .osc_enable(osc_enable),
		.core_clk_enable(core_clk_enable), .ale_out(ale_out),
		.program_store_strobe_out(ps_out), .powerdown_active(pd), .idle_active(idle));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic summarize;
		$display("errors %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("FAIL %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask : chk
	// One APB transfer: setup, access held until ready is sampled, then one idle edge
	task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h00_0000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		if (pready !== 1'b1) begin
			$display("FAIL pready expected 1 seen %b", pready);
			n_errors++;
			summarize();
		end else begin
			// Data and response taken at the edge where ready is seen high
			q = prdata[7:0];
			e = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
			@(posedge clk_sys);
		end
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [7:0] d); xfer(a, 1'b1, d); endtask : wr
	task automatic rd(input logic [11:0] a); xfer(a, 1'b0, 8'h00); endtask : rd
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst, psel, penable, pwrite, pin_n, irq_wake, ale_in, ps_in} <= 8'h83;
		{paddr, pwdata} <= '0;
		n_errors = 0;
		tests_run = 0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("run clocks", 8'h03, {6'h00, osc_enable, core_clk_enable});
		rd(12'h000); chk("ctl reset", 8'h00, q);
		rd(12'h004); chk("status", 8'h08, q);
		chk("mapped no err", 8'h00, {7'h00, e});
		rd(12'h00c); chk("unmapped err", 8'h01, {7'h00, e});
		wr(12'h100, 8'h5a);
		wr(12'h008, 8'h33);
		rd(12'h008); chk("scratch", 8'h33, q);
		wr(12'h000, 8'hcf); chk("both bits no pd", 8'h00, {7'h00, pd});
		rd(12'h000); chk("ctl readback", 8'h8c, q);
		rd(12'h004); chk("both bits unarmed", 8'h08, q);
		wr(12'h000, 8'h02);
		rd(12'h004); chk("armed", 8'h0c, q);
		rd(12'h000); chk("arm reads zero", 8'h00, q);
		wr(12'h000, 8'h04);
		wr(12'h000, 8'h40); chk("cancelled arm", 8'h00, {7'h00, pd});
		// Idle entry and wake, with core strobes low to show pass and hold
		ale_in <= 1'b0;
		ps_in  <= 1'b0;
		wr(12'h000, 8'h01);
		chk("strobe pass", 8'h00, {6'h00, ale_out, ps_out});
		wr(12'h000, 8'h20);
		chk("idle entered", 8'h0c, {4'h0, idle, osc_enable, core_clk_enable, pd});
		chk("idle strobes", 8'h03, {6'h00, ale_out, ps_out});
		irq_wake <= 1'b1;
		repeat (4) @(posedge clk_sys);
		irq_wake <= 1'b0;
		ale_in   <= 1'b1;
		ps_in    <= 1'b1;
		chk("idle woken", 8'h06, {4'h0, idle, osc_enable, core_clk_enable, pd});
		pin_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		wr(12'h000, 8'h01);
		wr(12'h000, 8'h20); chk("pin high idle", 8'h00, {7'h00, idle});
		wr(12'h000, 8'h02);
		wr(12'h000, 8'h40); chk("pin high pd", 8'h00, {7'h00, pd});
		pin_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		// Read-modify-write style: flag bits ride along with arm and start
		wr(12'h000, 8'h8e);
		wr(12'h000, 8'hcc);
		chk("pd entered", 8'h01, {7'h00, pd});
		chk("osc stopped", 8'h00, {7'h00, osc_enable});
		chk("strobes low", 8'h00, {6'h00, ale_out, ps_out});
		psel <= 1'b1;
		irq_wake <= 1'b1;
		@(posedge clk_sys);
		penable <= 1'b1;
		repeat (8) begin
			@(posedge clk_sys);
			chk("ready in pd", 8'h00, {7'h00, pready});
		end
		chk("pd kept", 8'h01, {7'h00, pd});
		{rst, psel, penable, irq_wake} <= 4'h8;
		@(posedge clk_sys);
		chk("osc restart", 8'h01, {7'h00, osc_enable});
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rd(12'h100); chk("store kept", 8'h5a, q);
		rd(12'h008); chk("scratch reset", 8'h00, q);
		rd(12'h000); chk("ctl cleared", 8'h00, q);
		chk("run after reset", 8'h06, {4'h0, idle, osc_enable, core_clk_enable, pd});
		summarize();
	end
endmodule : tb_power_down_entry_exit
bind pwr_ctrl pwr_ctrl_monitor mon (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .power_saving_enable_pin_n, .osc_enable, .ale_out,
	.program_store_strobe_out, .powerdown_active, .idle_active);
`default_nettype wire
